/* inc/sarc_pkg.sv */
// Shared constants and types for the SAR converter control block
package sarc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int HI_W = RES_W - DATA_W;

  localparam logic [ADDR_W-1:0] REG_SC1 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SC2 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_RHI = 4'h2;
  localparam logic [ADDR_W-1:0] REG_RLO = 4'h3;
  localparam logic [ADDR_W-1:0] REG_CVH = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CVL = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CFG = 4'h6;
  localparam logic [ADDR_W-1:0] REG_PIN = 4'h7;
  localparam logic [ADDR_W-1:0] REG_TICK = 4'h8;
  localparam logic [ADDR_W-1:0] REG_PWR = 4'h9;

  localparam int SC1_DONE = 7;
  localparam int SC1_IRQ_EN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC1_CH = 0;
  localparam int SC2_ACTIVE = 7;
  localparam int SC2_HWTRIG = 6;
  localparam int SC2_CMP_EN = 5;
  localparam int SC2_CMP_GE = 4;
  localparam int CFG_LOW_PWR = 7;
  localparam int CFG_DIV = 5;
  localparam int CFG_LONG = 4;
  localparam int CFG_MODE10 = 2;
  localparam int CFG_CLK = 0;
  localparam int TICK_SRC = 4;
  localparam int TICK_PER = 0;
  localparam int PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE = 1;
  localparam int PWR_BANDGAP_BUFFER_ENABLE = 0;

  localparam logic [CH_W-1:0] CH_OFF = 5'h1F;
  localparam logic [CH_W-1:0] CH_TEMP = 5'h1A;
  localparam logic [CH_W-1:0] CH_BANDGAP = 5'h1B;

  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_LOCAL = 2'h3;

  localparam logic [4:0] SHORT_SAMPLE = 5'h04;
  localparam logic [4:0] LONG_SAMPLE = 5'h18;
  localparam logic [1:0] SETTLE_CYC = 2'h3;
  localparam logic [3:0] TOP_BIT = 4'h9;
  localparam logic [RES_W-1:0] CODE_MID = 10'h200;
  localparam logic [2:0] TICK_OFF = 3'h0;
  localparam int TICK_SHIFT = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sarc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sarc_bus_t;
endpackage

/* rtl/sarc_ctrl.sv */
// SAR converter control: registers, conversion sequencer, compare and trigger
//
// Summary of operation
// - With hardware trigger on and channel not all ones, each tick counter overflow while idle starts a conversion.
// - Tick counter clocks from external reference or the 32 kHz source.
// - Tick counter runs freely; overflow period set by source and period select.
// - Tick counter triggers in run, wait and stop level three.
// - Conversions in stop level three need the low-voltage stop enable set.
// - Only one analog pin enable register exists.
// - Software sets the bandgap buffer enable before converting the bandgap channel.
// - Results come from 10-bit successive approximation.
// - Results are right-justified in 10-bit or 8-bit format.
// - Single mode returns to idle after one result; continuous keeps going.
// - Sample time and speed/power trade-off are configurable.
// - A completion flag and interrupt report an available result.
// - Converter clock selects among four sources, one a local async clock and one an unwired alternate that never ticks.
// - Each result is compared less-than or greater-or-equal; match raises interrupt.
// - Channel select field picks one of up to 28 inputs.
// - Writing control one aborts; starts anew unless channel is all ones or hardware trigger is on.
// - Flag sets per conversion or on compare match; write or low read clears.
// - Interrupt asserts when flag is set with interrupt enable high.
// - Hardware trigger starts continuous run, or exactly one conversion in single.
// - Active bit is set from start until completion or abort.
`timescale 1ns/1ps
module sarc_ctrl #(
  parameter int TICK_W = 16
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire sarc_pkg::sarc_bus_t BUS_IN,
  output logic [sarc_pkg::DATA_W-1:0] RDATA_OUT,
  input wire logic COMP_IN,
  input wire logic ASYNC_CLK_IN,
  input wire logic EXT_REF_CLK_IN,
  input wire logic LPO_CLK_IN,
  input wire logic STOP_LEVEL_THREE_IN,
  output logic DONE_IRQ_OUT,
  output logic SAMPLE_OUT,
  output logic ANALOG_ON_OUT,
  output logic [sarc_pkg::RES_W-1:0] SAR_CODE_OUT,
  output logic [sarc_pkg::CH_W-1:0] CHANNEL_OUT,
  output logic LOW_POWER_OUT,
  output logic [sarc_pkg::DATA_W-1:0] PIN_ENABLE_OUT,
  output logic BANDGAP_BUF_OUT
);
  import sarc_pkg::*;

  logic [DATA_W-1:0] wd;
  logic wr_sc1;
  logic rd_rlo;
  logic irq_en;
  logic cont_en;
  logic [CH_W-1:0] chan;
  logic hw_trig_en;
  logic cmp_en;
  logic cmp_ge;
  logic [RES_W-1:0] cv;
  logic [1:0] clk_div;
  logic long_smp;
  logic mode10;
  logic [1:0] clk_sel;
  logic tick_src;
  logic [2:0] tick_per;
  logic low_voltage_detect_stop_enable;
  logic done_flag;
  logic [RES_W-1:0] result;
  logic [DATA_W-1:0] rd_val;
  logic [1:0] pin_raw;
  logic [1:0] sy1;
  logic [1:0] sy2;
  logic async_d;
  logic comp_s;
  logic async_edge;
  logic bus_half;
  logic src_tick;
  logic [2:0] div_cnt;
  logic [2:0] div_last;
  logic adck_tick;
  logic tick_ovf;
  logic halted;
  logic abort;
  logic sw_go;
  logic hw_go;
  sarc_state_t state;
  sarc_state_t next_state;
  logic enter_smp;
  logic enter_cnv;
  logic [4:0] smp_cnt;
  logic [1:0] settle;
  logic [3:0] bit_idx;
  logic step;
  logic conv_end;
  logic [RES_W-1:0] kept;
  logic [RES_W-1:0] fmt;
  logic [RES_W-1:0] cv_eff;
  logic cmp_true;
  logic set_done;

  localparam logic [RES_W-1:0] CODE_ONE = 10'h001;
  function automatic logic [RES_W-1:0] bitm(input logic [3:0] i);
    bitm = CODE_ONE << i;
  endfunction

  assign wd = BUS_IN.wdata;
  assign wr_sc1 = BUS_IN.wr && (BUS_IN.addr == REG_SC1);
  assign rd_rlo = BUS_IN.rd && (BUS_IN.addr == REG_RLO);

  // Software-written configuration
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_en <= 1'h0;
      cont_en <= 1'h0;
      chan <= CH_OFF;
      hw_trig_en <= 1'h0;
      cmp_en <= 1'h0;
      cmp_ge <= 1'h0;
      cv <= '0;
      LOW_POWER_OUT <= 1'h0;
      clk_div <= 2'h0;
      long_smp <= 1'h0;
      mode10 <= 1'h0;
      clk_sel <= CLK_BUS;
      PIN_ENABLE_OUT <= '0;
      tick_src <= 1'h0;
      tick_per <= TICK_OFF;
      low_voltage_detect_stop_enable <= 1'h0;
      BANDGAP_BUF_OUT <= 1'h0;
    end else if (BUS_IN.wr) begin
      case (BUS_IN.addr)
        REG_SC1: begin
          irq_en <= wd[SC1_IRQ_EN];
          cont_en <= wd[SC1_CONT];
          chan <= wd[SC1_CH +: CH_W];
        end
        REG_SC2: begin
          hw_trig_en <= wd[SC2_HWTRIG];
          cmp_en <= wd[SC2_CMP_EN];
          cmp_ge <= wd[SC2_CMP_GE];
        end
        REG_CVH: cv[RES_W-1:DATA_W] <= wd[HI_W-1:0];
        REG_CVL: cv[DATA_W-1:0] <= wd;
        REG_CFG: begin
          LOW_POWER_OUT <= wd[CFG_LOW_PWR];
          clk_div <= wd[CFG_DIV +: 2];
          long_smp <= wd[CFG_LONG];
          mode10 <= wd[CFG_MODE10];
          clk_sel <= wd[CFG_CLK +: 2];
        end
        REG_PIN: PIN_ENABLE_OUT <= wd;
        REG_TICK: begin
          tick_src <= wd[TICK_SRC];
          tick_per <= wd[TICK_PER +: 3];
        end
        REG_PWR: begin
          low_voltage_detect_stop_enable <= wd[PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE];
          BANDGAP_BUF_OUT <= wd[PWR_BANDGAP_BUFFER_ENABLE];
        end
        default: ;
      endcase
    end
  end

  // Read view; unmapped offsets, including absent pin enable registers, read zero
  always_comb begin
    rd_val = '0;
    case (BUS_IN.addr)
      REG_SC1: begin
        rd_val[SC1_DONE] = done_flag;
        rd_val[SC1_IRQ_EN] = irq_en;
        rd_val[SC1_CONT] = cont_en;
        rd_val[SC1_CH +: CH_W] = chan;
      end
      REG_SC2: begin
        rd_val[SC2_ACTIVE] = (state != ST_IDLE);
        rd_val[SC2_HWTRIG] = hw_trig_en;
        rd_val[SC2_CMP_EN] = cmp_en;
        rd_val[SC2_CMP_GE] = cmp_ge;
      end
      REG_RHI: rd_val[HI_W-1:0] = result[RES_W-1:DATA_W];
      REG_RLO: rd_val = result[DATA_W-1:0];
      REG_CVH: rd_val[HI_W-1:0] = cv[RES_W-1:DATA_W];
      REG_CVL: rd_val = cv[DATA_W-1:0];
      REG_CFG: begin
        rd_val[CFG_LOW_PWR] = LOW_POWER_OUT;
        rd_val[CFG_DIV +: 2] = clk_div;
        rd_val[CFG_LONG] = long_smp;
        rd_val[CFG_MODE10] = mode10;
        rd_val[CFG_CLK +: 2] = clk_sel;
      end
      REG_PIN: rd_val = PIN_ENABLE_OUT;
      REG_TICK: begin
        rd_val[TICK_SRC] = tick_src;
        rd_val[TICK_PER +: 3] = tick_per;
      end
      REG_PWR: begin
        rd_val[PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE] = low_voltage_detect_stop_enable;
        rd_val[PWR_BANDGAP_BUFFER_ENABLE] = BANDGAP_BUF_OUT;
      end
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RDATA_OUT <= '0;
    end else begin
      RDATA_OUT <= BUS_IN.rd ? rd_val : '0;
    end
  end

  // Comparator and local async clock arrive from the analog side
  assign pin_raw = {ASYNC_CLK_IN, COMP_IN};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        sy1[i] <= 1'h0;
        sy2[i] <= 1'h0;
      end else begin
        sy1[i] <= pin_raw[i];
        sy2[i] <= sy1[i];
      end
    end
  end
  assign comp_s = sy2[0];

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      async_d <= 1'h0;
      bus_half <= 1'h0;
    end else begin
      async_d <= sy2[1];
      bus_half <= ~bus_half;
    end
  end
  assign async_edge = sy2[1] & ~async_d;

  // Alternate source is not wired on this device, so it never ticks
  always_comb begin
    case (clk_sel)
      CLK_BUS: src_tick = 1'h1;
      CLK_BUS_DIV2: src_tick = bus_half;
      CLK_LOCAL: src_tick = async_edge;
      default: src_tick = 1'h0;
    endcase
  end

  assign div_last = (3'h1 << clk_div) - 3'h1;
  assign adck_tick = src_tick && (div_cnt == div_last);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      div_cnt <= 3'h0;
    end else if (src_tick) begin
      div_cnt <= (div_cnt == div_last) ? 3'h0 : div_cnt + 3'h1;
    end
  end

  sarc_tick #(
    .CNT_W(TICK_W)
  ) u_tick (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .ext_ref_in(EXT_REF_CLK_IN),
    .lpo_in(LPO_CLK_IN),
    .src_sel_in(tick_src),
    .period_sel_in(tick_per),
    .overflow_out(tick_ovf)
  );

  assign halted = STOP_LEVEL_THREE_IN && !low_voltage_detect_stop_enable;
  assign abort = wr_sc1 || halted;
  assign sw_go = (wd[SC1_CH +: CH_W] != CH_OFF) && !hw_trig_en;
  assign hw_go = hw_trig_en && tick_ovf && (chan != CH_OFF);

  // Sequencer; a write always wins over the running conversion
  always_comb begin
    next_state = state;
    if (halted) begin
      next_state = ST_IDLE;
    end else if (wr_sc1) begin
      next_state = sw_go ? ST_SAMPLE : ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (hw_go) next_state = ST_SAMPLE;
        ST_SAMPLE: if (adck_tick && smp_cnt == 5'h00) next_state = ST_CONVERT;
        ST_CONVERT: if (conv_end) next_state = cont_en ? ST_SAMPLE : ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  assign enter_smp = (next_state == ST_SAMPLE) && (state != ST_SAMPLE || wr_sc1);
  assign enter_cnv = (next_state == ST_CONVERT) && (state != ST_CONVERT);
  assign step = (state == ST_CONVERT) && adck_tick && (settle == 2'h0) && !abort;
  assign conv_end = step && (bit_idx == 4'h0);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      smp_cnt <= 5'h00;
    end else if (enter_smp) begin
      smp_cnt <= (long_smp ? LONG_SAMPLE : SHORT_SAMPLE) - 5'h01;
    end else if (state == ST_SAMPLE && adck_tick && smp_cnt != 5'h00) begin
      smp_cnt <= smp_cnt - 5'h01;
    end
  end

  // Settle gap lets the trial code reach the comparator through its synchroniser
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      settle <= 2'h0;
    end else if (enter_cnv || step) begin
      settle <= SETTLE_CYC;
    end else if (settle != 2'h0) begin
      settle <= settle - 2'h1;
    end
  end

  // Comparator high means the input is at or above the trial code
  assign kept = comp_s ? SAR_CODE_OUT : SAR_CODE_OUT & ~bitm(bit_idx);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bit_idx <= 4'h0;
      SAR_CODE_OUT <= '0;
    end else if (enter_cnv) begin
      bit_idx <= TOP_BIT;
      SAR_CODE_OUT <= CODE_MID;
    end else if (step) begin
      bit_idx <= bit_idx - 4'h1;
      SAR_CODE_OUT <= (bit_idx != 4'h0) ? kept | bitm(bit_idx - 4'h1) : kept;
    end
  end

  assign fmt = mode10 ? kept : {{HI_W{1'b0}}, kept[RES_W-1 -: DATA_W]};
  assign cv_eff = mode10 ? cv : {{HI_W{1'b0}}, cv[DATA_W-1:0]};
  assign cmp_true = cmp_ge ? (fmt >= cv_eff) : (fmt < cv_eff);
  assign set_done = conv_end && (!cmp_en || cmp_true);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      result <= '0;
    end else if (set_done) begin
      result <= fmt;
    end
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      done_flag <= 1'h0;
    end else if (set_done) begin
      done_flag <= 1'h1;
    end else if (wr_sc1 || rd_rlo) begin
      done_flag <= 1'h0;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DONE_IRQ_OUT <= 1'h0;
      SAMPLE_OUT <= 1'h0;
      ANALOG_ON_OUT <= 1'h0;
      CHANNEL_OUT <= CH_OFF;
    end else begin
      DONE_IRQ_OUT <= done_flag && irq_en;
      SAMPLE_OUT <= (next_state == ST_SAMPLE);
      ANALOG_ON_OUT <= (next_state != ST_IDLE);
      CHANNEL_OUT <= chan;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_done_set;
    set_done |=> done_flag ##1 (done_flag || wr_sc1 || rd_rlo);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag missed a completion");

  property p_done_clr;
    (rd_rlo && !set_done) |=> !done_flag;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared by low read");

  property p_irq;
    (done_flag && irq_en) |=> DONE_IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing with flag and enable");

  property p_abort_off;
    (wr_sc1 && wd[SC1_CH +: CH_W] == CH_OFF) |=> (state == ST_IDLE) && !ANALOG_ON_OUT;
  endproperty
  a_abort_off: assert property (p_abort_off) else $error("write with channel off did not stop");

  property p_sw_start;
    (wr_sc1 && sw_go && !halted) |=> (state == ST_SAMPLE) && SAMPLE_OUT;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("write did not start a conversion");

  property p_single;
    (conv_end && !cont_en) |=> (state == ST_IDLE) && !ANALOG_ON_OUT;
  endproperty
  a_single: assert property (p_single) else $error("single mode did not return to idle");

  property p_cont;
    (conv_end && cont_en) |=> (state == ST_SAMPLE);
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode stopped");

  property p_hw;
    (state == ST_IDLE && hw_go && !abort) |=> (state == ST_SAMPLE);
  endproperty
  a_hw: assert property (p_hw) else $error("tick overflow did not start a conversion");

  property p_stop;
    halted |=> (state == ST_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("conversion ran in stop without enable");

  property p_active;
    (BUS_IN.rd && BUS_IN.addr == REG_SC2 && state != ST_IDLE) |=> RDATA_OUT[SC2_ACTIVE];
  endproperty
  a_active: assert property (p_active) else $error("active bit low during conversion");

  property p_fmt8;
    (set_done && !mode10) |=> (result[RES_W-1:DATA_W] == '0) ##1 $stable(result) || set_done;
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("8-bit result has high bits set");

  property p_cmp_block;
    (conv_end && cmp_en && !cmp_true && !done_flag && !set_done) |=> !done_flag;
  endproperty
  a_cmp_block: assert property (p_cmp_block) else $error("flag set without compare match");

  c_conv_done: cover property (conv_end ##1 done_flag);
  c_hw_start: cover property (hw_go ##1 state == ST_SAMPLE);
  c_cont_run: cover property (conv_end && cont_en ##1 state == ST_SAMPLE);
  c_abort: cover property (state == ST_CONVERT && wr_sc1);
endmodule

/* rtl/sarc_tick.sv */
// Free-running periodic tick counter producing the hardware trigger
`timescale 1ns/1ps
module sarc_tick #(
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ext_ref_in,
  input wire logic lpo_in,
  input wire logic src_sel_in,
  input wire logic [2:0] period_sel_in,
  output logic overflow_out
);
  import sarc_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [1:0] raw;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic [1:0] edge_seen;
  logic src_edge;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  assign raw = {lpo_in, ext_ref_in};

  // Both tick sources are foreign clocks, sampled as levels
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
      end
    end
    assign edge_seen[i] = s2[i] & ~s3[i];
  end

  assign src_edge = src_sel_in ? edge_seen[1] : edge_seen[0];
  assign limit = (CNT_ONE << (int'(period_sel_in) + TICK_SHIFT)) - CNT_ONE;

  // Not gated by any power mode, so triggers keep coming in wait and stop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
      overflow_out <= 1'b0;
    end else if (period_sel_in == TICK_OFF) begin
      cnt <= '0;
      overflow_out <= 1'b0;
    end else begin
      overflow_out <= 1'b0;
      if (src_edge) begin
        if (cnt >= limit) begin
          cnt <= '0;
          overflow_out <= 1'b1;
        end else begin
          cnt <= cnt + CNT_ONE;
        end
      end
    end
  end
endmodule

/* verification/sarc_comp_model.sv */
// Comparator stand-in for the analog front end
`timescale 1ns/1ps
module sarc_comp_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic on_in,
  input wire logic [9:0] code_in,
  input wire logic [9:0] level_in,
  output logic comp_out
);
  logic idle_pat;
  // Powered down: toggle, since a held level could hide a stale read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_pat <= 1'b0;
    end else begin
      idle_pat <= ~idle_pat;
    end
  end
  always_comb begin
    comp_out = on_in ? (level_in >= code_in) : idle_pat;
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ps
module testbench;
  import sarc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic async_clk = 1'b0;
  logic ext_clk = 1'b0;
  logic lpo_clk = 1'b0;
  logic stop_level_three = 1'b0;
  sarc_bus_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] pins;
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] level = 10'h2D7;
  logic [CH_W-1:0] chan;
  logic comp, irq, sample, analog_on, low_pwr, bg_buf;
  int fail_count = 0;
  int checks = 0;

  always #50 ref_clk = ~ref_clk;
  always #65 async_clk = ~async_clk;
  always #500 ext_clk = ~ext_clk;
  // Slow source shortened for run time
  always #1000 lpo_clk = ~lpo_clk;

  sarc_ctrl #(.TICK_W(16)) sarc_ctrl_inst (
    .REF_CLK_IN(ref_clk), .RST_IN(rst), .BUS_IN(bus), .RDATA_OUT(rdata), .COMP_IN(comp),
    .ASYNC_CLK_IN(async_clk), .EXT_REF_CLK_IN(ext_clk), .LPO_CLK_IN(lpo_clk), .STOP_LEVEL_THREE_IN(stop_level_three),
    .DONE_IRQ_OUT(irq), .SAMPLE_OUT(sample), .ANALOG_ON_OUT(analog_on), .SAR_CODE_OUT(code),
    .CHANNEL_OUT(chan), .LOW_POWER_OUT(low_pwr), .PIN_ENABLE_OUT(pins), .BANDGAP_BUF_OUT(bg_buf)
  );

  sarc_comp_model sarc_comp_model_inst (
    .clk_in(ref_clk), .rst_in(rst), .on_in(analog_on), .code_in(code), .level_in(level), .comp_out(comp)
  );

  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Polls the flag; each poll costs two cycles
  task automatic wait_done(input int n);
    int i;
    logic [7:0] s;
    i = 0;
    rd(REG_SC1, s);
    while (s[SC1_DONE] !== 1'b1 && i < n) begin
      rd(REG_SC1, s);
      i++;
    end
    chk("done flag", 10'h001, {9'h000, s[SC1_DONE]});
  endtask

  task automatic t_reset();
    logic [7:0] s;
    rd(REG_SC1, s);
    chk("sc1 reset", 10'h01F, {2'h0, s});
    chk("channel reset", 10'h01F, {5'h00, chan});
    chk("analog on reset", 10'h000, {9'h000, analog_on});
  endtask

  task automatic t_pins();
    logic [7:0] s;
    wr(REG_PIN, 8'hA5);
    rd(REG_PIN, s);
    chk("pin reg", 10'h0A5, {2'h0, s});
    chk("pin out", 10'h0A5, {2'h0, pins});
    wr(4'hA, 8'hFF);
    rd(4'hA, s);
    chk("unmapped", 10'h000, {2'h0, s});
  endtask

  task automatic t_conv(input logic [7:0] cfg, input logic [4:0] ch);
    logic [7:0] hi, lo, s;
    logic [9:0] exp;
    exp = cfg[CFG_MODE10] ? level : {2'h0, level[9:2]};
    wr(REG_PWR, 8'h01);
    wr(REG_CFG, cfg);
    wr(REG_SC1, {3'b010, ch});
    wait_done(600);
    chk("irq", 10'h001, {9'h000, irq});
    chk("channel", {5'h00, ch}, {5'h00, chan});
    chk("low power", {9'h000, cfg[CFG_LOW_PWR]}, {9'h000, low_pwr});
    chk("bandgap buf", 10'h001, {9'h000, bg_buf});
    rd(REG_RHI, hi);
    rd(REG_RLO, lo);
    chk("result", exp, {hi[1:0], lo});
    rd(REG_SC1, s);
    chk("flag cleared", 10'h000, {9'h000, s[SC1_DONE]});
    chk("irq cleared", 10'h000, {9'h000, irq});
    chk("idle after one", 10'h000, {9'h000, analog_on});
    chk("sar code", level, code);
  endtask

  task automatic t_abort();
    logic [7:0] s;
    wr(REG_CFG, 8'h04);
    wr(REG_SC1, 8'h01);
    repeat (10) @(posedge ref_clk);
    rd(REG_SC2, s);
    chk("active", 10'h001, {9'h000, s[SC2_ACTIVE]});
    wr(REG_SC1, 8'h02);
    #1;
    chk("sampling", 10'h001, {9'h000, sample});
    rd(REG_SC2, s);
    chk("restarted", 10'h001, {9'h000, s[SC2_ACTIVE]});
    wr(REG_SC1, 8'h1F);
    rd(REG_SC2, s);
    chk("aborted", 10'h000, {9'h000, s[SC2_ACTIVE]});
    repeat (60) @(posedge ref_clk);
    rd(REG_SC1, s);
    chk("no result", 10'h01F, {2'h0, s});
    chk("powered down", 10'h000, {9'h000, analog_on});
  endtask

  task automatic t_compare();
    logic [7:0] s;
    @(posedge ref_clk);
    level <= 10'h155;
    wr(REG_CVH, 8'h02);
    wr(REG_CVL, 8'h00);
    wr(REG_SC2, 8'h30);
    wr(REG_SC1, 8'h41);
    repeat (120) @(posedge ref_clk);
    rd(REG_SC1, s);
    chk("ge miss", 10'h000, {9'h000, s[SC1_DONE]});
    chk("ge miss irq", 10'h000, {9'h000, irq});
    wr(REG_SC2, 8'h20);
    wr(REG_SC1, 8'h41);
    wait_done(200);
    rd(REG_RLO, s);
    chk("lt result", 10'h055, {2'h0, s});
    wr(REG_SC2, 8'h00);
    @(posedge ref_clk);
    level <= 10'h2D7;
  endtask

  task automatic t_cont();
    logic [7:0] s;
    wr(REG_SC1, 8'h21);
    wait_done(200);
    rd(REG_RLO, s);
    chk("cont result", 10'h0D7, {2'h0, s});
    wait_done(200);
    wr(REG_SC1, 8'h1F);
    repeat (2) @(posedge ref_clk);
    chk("cont stopped", 10'h000, {9'h000, analog_on});
  endtask

  task automatic t_hw(input logic src);
    logic [7:0] s;
    wr(REG_TICK, {3'h0, src, 4'h1});
    wr(REG_SC2, 8'h40);
    wr(REG_SC1, 8'h01);
    wait_done(1000);
    rd(REG_RLO, s);
    chk("hw result", 10'h0D7, {2'h0, s});
    wait_done(1000);
    wr(REG_SC2, 8'h00);
    wr(REG_SC1, 8'h1F);
    wr(REG_TICK, 8'h00);
  endtask

  task automatic t_stop_level_three();
    logic [7:0] s;
    wr(REG_PWR, 8'h00);
    @(posedge ref_clk);
    stop_level_three <= 1'b1;
    wr(REG_SC1, 8'h01);
    repeat (80) @(posedge ref_clk);
    rd(REG_SC2, s);
    chk("stop_level_three blocked", 10'h000, {9'h000, s[SC2_ACTIVE]});
    wr(REG_PWR, 8'h03);
    wr(REG_SC1, 8'h01);
    wait_done(200);
    rd(REG_RLO, s);
    @(posedge ref_clk);
    stop_level_three <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_pins();
    t_conv(8'h04, 5'h01);
    t_conv(8'h05, 5'h02);
    t_conv(8'h07, 5'h03);
    t_conv(8'h00, 5'h01);
    t_conv(8'hF4, CH_BANDGAP);
    t_conv(8'h77, CH_TEMP);
    t_abort();
    t_compare();
    t_cont();
    t_hw(1'b0);
    t_hw(1'b1);
    t_stop_level_three();
    complete_run();
  end
endmodule
